// ---- shared/sce_pkg.sv ----
`default_nettype none
// ************************************************************
// shared constants for the serial controller
// ************************************************************
package sce_pkg;
  localparam int          NUM_CS_DEF   = 4;        // chip select lines
  localparam int          DIV_W        = 8;        // baud divisor width
  localparam int          WORD_W       = 8;        // data word width
  localparam logic [7:0]  DIV_ONE      = 8'h01;    // divisor value that runs at full rate
  localparam logic [7:0]  DIV_ZERO     = 8'h00;    // divisor value treated as one
  localparam logic [7:0]  TX_IDLE_WORD = 8'hFF;    // slave shifts this when nothing is loaded
  localparam logic [7:0]  RX_RESET     = 8'h00;    // receive data after reset
  localparam logic [3:0]  LAST_EDGE    = 4'hF;     // sixteenth clock edge of a word
  localparam logic [2:0]  LAST_BIT     = 3'h7;     // eighth bit of a slave word

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_EXTRA = 4'b0100,
    ST_DONE  = 4'b1000
  } sce_state_t;
endpackage
`default_nettype wire

// ---- rtl/sce_spi_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module sce_spi_ctrl #(
  parameter int NUM_CS = sce_pkg::NUM_CS_DEF
) (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  input  wire logic                                  link_clk,
  input  wire logic                                  ctl_enable,
  input  wire logic                                  ctl_disable,
  input  wire logic                                  soft_reset_bit,
  input  wire logic                                  master_mode,
  input  wire logic                                  mode_fault_disable,
  input  wire logic                                  cs_hold_after_transfer,
  input  wire logic                                  clock_polarity,
  input  wire logic                                  capture_phase,
  input  wire logic [NUM_CS*sce_pkg::DIV_W-1:0]      baud_divisor,
  input  wire logic [$clog2(NUM_CS)-1:0]             cs_select,
  input  wire logic                                  tx_wr,
  input  wire logic [sce_pkg::WORD_W-1:0]            tx_wdata,
  input  wire logic                                  dma_wr,
  input  wire logic [sce_pkg::WORD_W-1:0]            dma_wdata,
  input  wire logic                                  rx_rd,
  input  wire logic                                  miso_i,
  input  wire logic                                  mosi_i,
  input  wire logic                                  ss_n_i,
  output logic                                       tx_empty_flag,
  output logic                                       dma_tx_req,
  output logic                                       rx_full,
  output logic [sce_pkg::WORD_W-1:0]                 rx_data_reg,
  output logic [$clog2(NUM_CS)-1:0]                  periph_select_field,
  output logic                                       ctl_enabled,
  output logic                                       mode_fault,
  output logic                                       busy,
  output logic                                       sck_o,
  output logic                                       sck_oe,
  output logic                                       mosi_o,
  output logic                                       mosi_oe,
  output logic                                       miso_o,
  output logic                                       miso_oe,
  output logic [NUM_CS-1:0]                          chip_select_lines_n
);
  import sce_pkg::*;

  localparam int CSW = $clog2(NUM_CS);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (NUM_CS < 2 || NUM_CS > 16) begin : g_bad_cs
    $error("NUM_CS must lie between 2 and 16");
  end

  // ************************************************************
  // decode helpers
  // ************************************************************
  // divisor of one chip select, zero taken as one
  function automatic logic [DIV_W-1:0] div_of(input logic [NUM_CS*DIV_W-1:0] bus,
                                              input int idx);
    logic [DIV_W-1:0] d;
    d = bus[idx*DIV_W +: DIV_W];
    return (d == DIV_ZERO) ? DIV_ONE : d;
  endfunction

  // active low one-hot chip select pattern
  function automatic logic [NUM_CS-1:0] csel_n(input logic [CSW-1:0] idx);
    logic [NUM_CS-1:0] v;
    v = '1;
    v[idx] = 1'b0;
    return v;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  sce_state_t          st_q;
  logic                en_q, mf_q, tx_empty_q, rx_full_q, busy_q;
  logic [WORD_W-1:0]   tx_data_q, msh_q, mrx_q, rx_data_q, slv_tx_q;
  logic [CSW-1:0]      cs_cur_q, prev_cs_q, psf_q;
  logic [DIV_W-1:0]    cnt_q;
  logic [3:0]          edge_q;
  logic                extra_q, sck_q, sck_oe_q, mosi_oe_q, miso_oe_q;
  logic [NUM_CS-1:0]   cs_n_q;
  logic [1:0]          ss_sync_q, miso_sync_q, done_sync_q, ack_sync_q;
  logic                done_seen_q, ld_tgl_q, lrst_req_q;
  // link domain
  logic [1:0]          lrs_q, ld_sync_q;
  logic [2:0]          lcnt_q;
  logic [WORD_W-1:0]   lrx_q, lsh_q, lword_q;
  logic                ldone_tgl_q, ltaken_q;

  logic                clr, wr_any, wr_ok, hold_block, start_m, other_one, extra_cond;
  logic                slv_done, ld_busy, start_s, capture_e, shift_e;
  logic [WORD_W-1:0]   wdata;
  logic [DIV_W-1:0]    div_cur;

  // ************************************************************
  // synchronisers from pins and the link domain
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ss_sync_q   <= 2'h3;
      miso_sync_q <= 2'h0;
      done_sync_q <= 2'h0;
      ack_sync_q  <= 2'h0;
    end else begin
      ss_sync_q   <= {ss_sync_q[0], ss_n_i};
      miso_sync_q <= {miso_sync_q[0], miso_i};
      done_sync_q <= {done_sync_q[0], ldone_tgl_q};
      ack_sync_q  <= {ack_sync_q[0], ltaken_q};
    end
  end
  // ************************************************************
  // request decode
  // ************************************************************
  assign clr        = rst | soft_reset_bit;
  assign wr_any     = tx_wr | dma_wr;
  assign wdata      = tx_wr ? tx_wdata : dma_wdata;
  assign wr_ok      = wr_any & en_q;
  assign hold_block = cs_hold_after_transfer & ~mode_fault_disable;
  assign start_m    = (st_q == ST_IDLE) & master_mode & en_q & ~tx_empty_q
                      & ~hold_block & ~wr_any;
  assign ld_busy    = ld_tgl_q != ack_sync_q[1];
  assign start_s    = ~master_mode & en_q & ~tx_empty_q & ~ld_busy & ~wr_any;
  assign slv_done   = done_sync_q[1] != done_seen_q;
  assign div_cur    = div_of(baud_divisor, int'(cs_select));
  assign capture_e  = capture_phase ? ~edge_q[0] : edge_q[0];
  assign shift_e    = capture_phase ? (edge_q[0] & (edge_q != LAST_EDGE))
                                    : (~edge_q[0] & (edge_q != 4'h0));

  // another chip select runs at divisor one
  always_comb begin
    other_one = 1'b0;
    for (int i = 0; i < NUM_CS; i++) begin
      if (i != int'(cs_select) && div_of(baud_divisor, i) == DIV_ONE) other_one = 1'b1;
    end
  end
  assign extra_cond = clock_polarity & ~capture_phase & (div_cur != DIV_ONE)
                      & other_one;

  // ************************************************************
  // enable and mode fault
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      en_q <= 1'b0;
      mf_q <= 1'b0;
    end else if (master_mode & en_q & ~mode_fault_disable & ~ss_sync_q[1]) begin
      mf_q <= 1'b1;                      // another master pulled select low
      en_q <= 1'b0;
    end else if (ctl_enable) begin
      mf_q <= 1'b0;
      en_q <= 1'b1;
    end else if (ctl_disable & master_mode) begin
      en_q <= 1'b0;
    end
  end
  // ************************************************************
  // transmit holding register and empty flag
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      tx_empty_q <= 1'b1;
      tx_data_q  <= RX_RESET;
      slv_tx_q   <= TX_IDLE_WORD;
      ld_tgl_q   <= 1'b0;
    end else if (wr_ok) begin
      tx_data_q  <= wdata;
      tx_empty_q <= 1'b0;                // disabled writes never reach here
    end else if (start_m) begin
      tx_empty_q <= 1'b1;
    end else if (start_s) begin
      slv_tx_q   <= tx_data_q;           // held stable until the link takes it
      ld_tgl_q   <= ~ld_tgl_q;
      tx_empty_q <= 1'b1;
    end
  end
  // ************************************************************
  // master shift engine
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      st_q     <= ST_IDLE;
      sck_q    <= 1'b0;
      cnt_q    <= DIV_ZERO;
      edge_q   <= 4'h0;
      msh_q    <= RX_RESET;
      mrx_q    <= RX_RESET;
      extra_q  <= 1'b0;
      cs_cur_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          sck_q <= clock_polarity;
          if (start_m) begin
            msh_q    <= tx_data_q;
            edge_q   <= 4'h0;
            cnt_q    <= div_cur - DIV_ONE;
            extra_q  <= extra_cond;
            cs_cur_q <= cs_select;
            st_q     <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cnt_q == DIV_ZERO) begin
            cnt_q  <= div_of(baud_divisor, int'(cs_cur_q)) - DIV_ONE;
            sck_q  <= ~sck_q;
            edge_q <= edge_q + 4'h1;
            if (capture_e) mrx_q <= {mrx_q[WORD_W-2:0], miso_sync_q[1]};
            if (shift_e) msh_q <= {msh_q[WORD_W-2:0], 1'b0};
            if (edge_q == LAST_EDGE) st_q <= extra_q ? ST_EXTRA : ST_DONE;
          end else cnt_q <= cnt_q - DIV_ONE;
        end
        ST_EXTRA: begin
          // one surplus pulse on the serial clock, no data moves
          if (cnt_q == DIV_ZERO) begin
            cnt_q  <= div_of(baud_divisor, int'(cs_cur_q)) - DIV_ONE;
            sck_q  <= ~sck_q;
            edge_q <= edge_q + 4'h1;
            if (edge_q[0]) st_q <= ST_DONE;
          end else cnt_q <= cnt_q - DIV_ONE;
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // ************************************************************
  // receive register, stale select field
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      rx_data_q   <= RX_RESET;
      rx_full_q   <= 1'b0;
      psf_q       <= '0;
      prev_cs_q   <= '0;
      done_seen_q <= 1'b0;
    end else begin
      done_seen_q <= done_sync_q[1];
      if (st_q == ST_DONE) begin
        rx_data_q <= mrx_q;
        rx_full_q <= 1'b1;               // set wins over a read
        psf_q     <= prev_cs_q;
        prev_cs_q <= cs_cur_q;
      end else if (slv_done & ~master_mode & en_q) begin
        rx_data_q <= lword_q;            // link word is stable for a whole word time
        rx_full_q <= 1'b1;
        psf_q     <= prev_cs_q;
      end else if (rx_rd) rx_full_q <= 1'b0;
    end
  end
  // ************************************************************
  // chip selects and pin enables
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      cs_n_q     <= '1;
      sck_oe_q   <= 1'b0;
      mosi_oe_q  <= 1'b0;
      miso_oe_q  <= 1'b0;
      busy_q     <= 1'b0;
      lrst_req_q <= 1'b1;
    end else begin
      lrst_req_q <= 1'b0;
      busy_q     <= st_q != ST_IDLE;
      sck_oe_q   <= master_mode & en_q;
      mosi_oe_q  <= master_mode & en_q;
      miso_oe_q  <= ~master_mode & en_q & ~ss_sync_q[1];
      if (st_q == ST_SHIFT || st_q == ST_EXTRA) begin
        cs_n_q <= csel_n(cs_cur_q);
      end else if (st_q == ST_DONE) begin
        if (!(cs_hold_after_transfer && cs_cur_q == '0)) cs_n_q <= '1;  // cs0 may stay held
      end else if (!(master_mode && en_q)) begin
        cs_n_q <= '1;
      end
    end
  end
  // ************************************************************
  // link domain: slave shift register on the external clock
  // ************************************************************
  always_ff @(posedge link_clk) begin
    lrs_q     <= {lrs_q[0], lrst_req_q};
    ld_sync_q <= {ld_sync_q[0], ld_tgl_q};
  end
  always_ff @(posedge link_clk) begin
    if (lrs_q[1]) begin
      lcnt_q      <= 3'h0;
      lrx_q       <= RX_RESET;
      lsh_q       <= TX_IDLE_WORD;
      lword_q     <= RX_RESET;
      ldone_tgl_q <= 1'b0;
      ltaken_q    <= 1'b0;
    end else if (!ss_n_i) begin
      // slave keeps running even when disabled
      lrx_q  <= {lrx_q[WORD_W-2:0], mosi_i};
      lcnt_q <= lcnt_q + 3'h1;
      if (lcnt_q == LAST_BIT) begin
        lword_q     <= {lrx_q[WORD_W-2:0], mosi_i};
        ldone_tgl_q <= ~ldone_tgl_q;
        if (ld_sync_q[1] != ltaken_q) begin
          lsh_q    <= slv_tx_q;
          ltaken_q <= ld_sync_q[1];
        end else lsh_q <= TX_IDLE_WORD;
      end else lsh_q <= {lsh_q[WORD_W-2:0], 1'b1};
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign tx_empty_flag       = tx_empty_q;
  assign dma_tx_req          = tx_empty_q;  // dma sees empty even when disabled
  assign rx_full             = rx_full_q;
  assign rx_data_reg         = rx_data_q;
  assign periph_select_field = psf_q;
  assign ctl_enabled         = en_q;
  assign mode_fault          = mf_q;
  assign busy                = busy_q;
  assign sck_o               = sck_q;
  assign sck_oe              = sck_oe_q;
  assign mosi_o              = msh_q[WORD_W-1];
  assign mosi_oe             = mosi_oe_q;
  assign miso_o              = lsh_q[WORD_W-1];
  assign miso_oe             = miso_oe_q;
  assign chip_select_lines_n = cs_n_q;
endmodule // sce_spi_ctrl
`default_nettype wire

// ---- verif/sce_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// port checker for the serial controller
// ************************************************************
module sce_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ctl_enable,
  input wire logic ctl_disable,
  input wire logic soft_reset_bit,
  input wire logic master_mode,
  input wire logic mode_fault_disable,
  input wire logic cs_hold_after_transfer,
  input wire logic tx_wr,
  input wire logic dma_wr,
  input wire logic tx_empty_flag,
  input wire logic dma_tx_req,
  input wire logic ctl_enabled,
  input wire logic sck_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a loaded word waits with chip select 0 hold and fault detection on
  sequence s_hold_pend;
    cs_hold_after_transfer && !mode_fault_disable && ctl_enabled && !tx_empty_flag
      && !soft_reset_bit;
  endsequence
  // a dma write offered while the controller is off
  sequence s_off_dma;
    !ctl_enabled && dma_wr && tx_empty_flag && !soft_reset_bit;
  endsequence
  a_hold_blocks_start: assert property (s_hold_pend |=> !tx_empty_flag)
    else $error("transfer started under chip select hold");
  a_off_keeps_empty: assert property (!ctl_enabled && !soft_reset_bit |=> $stable(tx_empty_flag))
    else $error("empty flag moved while disabled");
  a_write_clears_empty: assert property
    (ctl_enabled && (tx_wr || dma_wr) && !soft_reset_bit |=> !tx_empty_flag)
    else $error("enabled write did not clear empty flag");
  a_dma_lost_word: assert property (s_off_dma |=> dma_tx_req && tx_empty_flag)
    else $error("dma word taken while disabled");
  a_dma_req_tracks: assert property (dma_tx_req == tx_empty_flag)
    else $error("dma request differs from empty flag");
  a_slave_ignores_off: assert property
    (ctl_enabled && !master_mode && ctl_disable && !soft_reset_bit |=> ctl_enabled)
    else $error("slave mode obeyed disable");
  a_master_takes_off: assert property
    (ctl_enabled && master_mode && ctl_disable && !ctl_enable |=> !ctl_enabled)
    else $error("master mode ignored disable");
  a_enable_takes: assert property
    (ctl_enable && !ctl_disable && !soft_reset_bit && mode_fault_disable |=> ctl_enabled)
    else $error("enable not taken");
  a_oe_follows: assert property (ctl_enabled && master_mode && !soft_reset_bit |=> sck_oe)
    else $error("clock pin not driven in master mode");
  a_oe_slave_off: assert property ((!master_mode) [*2] |-> !sck_oe)
    else $error("clock pin driven in slave mode");
endmodule // sce_props
bind sce_spi_ctrl sce_props sce_props_inst (.ref_clk, .rst, .ctl_enable, .ctl_disable,
  .soft_reset_bit, .master_mode, .mode_fault_disable, .cs_hold_after_transfer, .tx_wr,
  .dma_wr, .tx_empty_flag, .dma_tx_req, .ctl_enabled, .sck_oe);
`default_nettype wire

// ---- verif/sce_periph_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// serial device on chip select 0
// ************************************************************
module sce_periph_model (
  input  wire logic sck,
  input  wire logic cs_n,
  output logic      miso,
  output int        edges
);
  localparam logic [7:0] REPLY = 8'hA5;  // answer word
  initial edges = 0;
  initial miso = 1'b0;
  // count every clock edge while selected
  always @(negedge cs_n) edges = 0;
  // count just after the edge: select and clock may move on the same system edge
  always @(sck) begin
    #0.1;
    if (!cs_n) edges = edges + 1;
  end
  // reply bit over the first 16 edges while selected, inverted level after them or once released
  always @(edges or cs_n) begin
    if (cs_n || edges > 15) miso = ~miso;
    else miso = REPLY[3'(7 - edges / 2)];
  end
endmodule // sce_periph_model
`default_nettype wire

// ---- verif/tb_spi_controller_errata_behaviour.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_spi_controller_errata_behaviour;
  import sce_pkg::*;
  logic ref_clk, rst, link_clk, ctl_enable, ctl_disable, soft_reset_bit, master_mode;
  logic mode_fault_disable, cs_hold_after_transfer, clock_polarity, capture_phase;
  logic tx_wr, dma_wr, rx_rd, miso_i, mosi_i, ss_n_i, tx_empty_flag, dma_tx_req, rx_full;
  logic ctl_enabled, busy, sck_o, sck_oe, miso_o, mode_fault;
  logic [31:0] baud_divisor;
  logic [1:0]  cs_select, periph_select_field;
  logic [7:0]  tx_wdata, dma_wdata, rx_data_reg;
  logic [3:0]  chip_select_lines_n;
  int          edges, fail_count, comparisons, cyc;
  // ************************************************************
  // device and far side
  // ************************************************************
  sce_spi_ctrl #(.NUM_CS(NUM_CS_DEF)) sce_spi_ctrl_inst (.ref_clk, .rst, .link_clk,
    .ctl_enable, .ctl_disable, .soft_reset_bit, .master_mode, .mode_fault_disable,
    .cs_hold_after_transfer, .clock_polarity, .capture_phase, .baud_divisor, .cs_select,
    .tx_wr, .tx_wdata, .dma_wr, .dma_wdata, .rx_rd, .miso_i, .mosi_i, .ss_n_i,
    .tx_empty_flag, .dma_tx_req, .rx_full, .rx_data_reg, .periph_select_field,
    .ctl_enabled, .mode_fault, .busy, .sck_o, .sck_oe, .mosi_o(), .mosi_oe(), .miso_o,
    .miso_oe(), .chip_select_lines_n);
  sce_periph_model sce_periph_model_inst (.sck(sck_o), .cs_n(chip_select_lines_n[0]),
    .miso(miso_i), .edges(edges));
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_n(string n, int e, int g);
    comparisons++;
    if (g != e) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask
  task wait_rx;
    for (int i = 0; i < 400 && rx_full !== 1'b1; i++) @(negedge ref_clk);
  endtask
  task sreset;
    pulse(soft_reset_bit);
    repeat (3) @(negedge ref_clk);
  endtask
  task lk;
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
  endtask
  // external master frame, off the system clock phase
  task automatic frame(logic [7:0] w, output logic [7:0] r);
    #1.3 ss_n_i = 1'b0;
    for (int b = 7; b >= 0; b--) begin
      mosi_i = w[b];
      r[b] = miso_o;
      lk();
    end
    #24 ss_n_i = 1'b1;
    mosi_i = ~mosi_i;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_hold;
    @(negedge ref_clk) mode_fault_disable = 1'b0;
    cs_hold_after_transfer = 1'b1;
    pulse(ctl_enable);
    tx_wdata = 8'h3C;
    pulse(tx_wr);
    repeat (60) @(negedge ref_clk);
    chk("tx_empty_flag", 8'h00, tx_empty_flag);
    chk("chip_select_lines_n", 8'h0F, chip_select_lines_n);
    mode_fault_disable = 1'b1;
    wait_rx();
    chk("rx_full", 8'h01, rx_full);
    chk_n("sck edges", 16, edges);
    sreset();
  endtask
  task automatic t_extra;
    int          ex[3] = '{18, 16, 16};
    logic [31:0] dv[3] = '{32'h01010102, 32'h01010101, 32'h01010102};
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk) baud_divisor = dv[k];
      clock_polarity = (k < 2);
      capture_phase = 1'b0;
      cs_hold_after_transfer = 1'b0;
      pulse(ctl_enable);
      tx_wdata = 8'h96;
      pulse(tx_wr);
      wait_rx();
      chk("rx_full", 8'h01, rx_full);
      chk_n("sck edges", ex[k], edges);
      sreset();
    end
  endtask
  task t_disable;
    @(negedge ref_clk) baud_divisor = 32'h01010108;
    pulse(ctl_enable);
    dma_wdata = 8'h71;
    pulse(dma_wr);
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge ref_clk);
    pulse(ctl_disable);
    chk("ctl_enabled", 8'h00, ctl_enabled);
    chk("tx_empty_flag", 8'h01, tx_empty_flag);
    repeat (3) begin
      dma_wdata = dma_wdata + 8'h11;
      pulse(dma_wr);
      chk("dma_tx_req", 8'h01, dma_tx_req);
    end
    tx_wdata = 8'h55;
    pulse(tx_wr);
    chk("tx_empty_flag", 8'h01, tx_empty_flag);
    pulse(ctl_enable);
    pulse(dma_wr);
    chk("tx_empty_flag", 8'h00, tx_empty_flag);
    sreset();
  endtask
  // select field trails the lines by one word; select low raises a mode fault
  task t_psf;
    @(negedge ref_clk) baud_divisor = 32'h01010101;
    cs_select = 2'h1;
    pulse(ctl_enable);
    for (int k = 0; k < 2; k++) begin
      tx_wdata = 8'hC3;
      pulse(tx_wr);
      wait_rx();
      chk("periph_select_field", 8'(k), periph_select_field);
      pulse(rx_rd);
    end
    cs_select = 2'h0;
    mode_fault_disable = 1'b0;
    ss_n_i = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("mode_fault", 8'h01, mode_fault);
    chk("ctl_enabled", 8'h00, ctl_enabled);
    ss_n_i = 1'b1;
    mode_fault_disable = 1'b1;
    sreset();
  endtask
  task automatic t_slave;
    logic [7:0] got;
    @(negedge ref_clk) master_mode = 1'b0;
    soft_reset_bit = 1'b1;
    #1.3 repeat (4) lk();
    @(negedge ref_clk) soft_reset_bit = 1'b0;
    #1.3 repeat (3) lk();  // link reset pipeline drains before the first frame
    pulse(ctl_enable);
    pulse(ctl_disable);
    chk("ctl_enabled", 8'h01, ctl_enabled);
    frame(8'h5A, got);
    chk("miso_o word", TX_IDLE_WORD, got);
    wait_rx();
    chk("rx_data_reg", 8'h5A, rx_data_reg);
    pulse(rx_rd);
    chk("rx_full", 8'h00, rx_full);
    pulse(soft_reset_bit);
    chk("ctl_enabled", 8'h00, ctl_enabled);
  endtask
  // main sequence
  initial begin
    {ctl_enable, ctl_disable, soft_reset_bit, tx_wr, dma_wr, rx_rd, link_clk, mosi_i} = '0;
    {master_mode, mode_fault_disable, capture_phase, ss_n_i, rst} = '1;
    {cs_hold_after_transfer, clock_polarity, cs_select, tx_wdata, dma_wdata} = '0;
    baud_divisor = 32'h01010101;
    {fail_count, comparisons, cyc} = '0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    chk("tx_empty_flag", 8'h01, tx_empty_flag);
    chk("chip_select_lines_n", 8'h0F, chip_select_lines_n);
    t_hold();
    t_extra();
    t_disable();
    t_psf();
    t_slave();
    stop_test();
  end
endmodule // tb_spi_controller_errata_behaviour
`default_nettype wire
